// *** abr_host.sv ***
module abr_host (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    abr_link_if.host link,
    input wire logic start_conv,
    input wire logic start_cal,
    output logic ready,
    output abr_pkg::abr_code_t result_code,
    output logic result_valid,
    output logic cal_done
);
    import abr_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_CNV, H_WAIT_BUSY, H_CLK_HIGH, H_CLK_LOW, H_CAL_LOW, H_CAL_HIGH
    } abr_host_state_t;

    abr_host_state_t state_reg;
    logic [PHASE_W-1:0] phase_reg;
    logic [EDGE_CNT_W-1:0] pulse_reg;
    abr_code_t shift_reg;
    logic cal_mode_reg;
    logic armed_reg;
    logic cnv_reg;
    logic sclk_reg;
    logic sdo_s1_reg;
    logic sdo_s2_reg;

    // Decoded conditions
    wire phase_zero;
    wire sample_now;
    wire frame_end;
    wire [EDGE_CNT_W-1:0] target;
    abr_code_t shift_next;

    assign phase_zero = (phase_reg == '0);
    assign target = cal_mode_reg ? EDGE_CNT_W'(CAL_PULSES) : EDGE_CNT_W'(RELEASE_EDGE);
    assign frame_end = (pulse_reg == target);
    // Sample late in the low half, after the falling edge has settled
    assign sample_now = ~cal_mode_reg && (pulse_reg != '0)
        && (pulse_reg <= EDGE_CNT_W'(RES_BITS));
    assign shift_next = sample_now ? {shift_reg[RES_BITS-2:0], sdo_s2_reg} : shift_reg;

    // Busy-bit variant selected permanently
    assign link.mode_select_input = MODE_BUSY_LEVEL;
    assign link.conversion_select = cnv_reg;
    assign link.sclk = sclk_reg;
    assign ready = (state_reg == H_IDLE);

    // Data line synchroniser
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sdo_s1_reg <= SDO_PULL_LEVEL;
            sdo_s2_reg <= SDO_PULL_LEVEL;
        end else if (clk_en) begin
            sdo_s1_reg <= link.sdo;
            sdo_s2_reg <= sdo_s1_reg;
        end
    end

    // Host sequencer and serial-clock divider
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= H_IDLE;
            phase_reg <= '0;
            pulse_reg <= '0;
            shift_reg <= '0;
            cal_mode_reg <= 1'b0;
            armed_reg <= 1'b0;
            cnv_reg <= CNV_RST;
            sclk_reg <= SCLK_RST;
            result_code <= '0;
            result_valid <= 1'b0;
            cal_done <= 1'b0;
        end else if (clk_en) begin
            result_valid <= 1'b0;
            cal_done <= 1'b0;
            unique case (state_reg)
                H_IDLE: begin
                    if (start_conv) begin
                        cnv_reg <= 1'b1;
                        phase_reg <= PHASE_W'(CNV_HIGH_CYCLES - 1);
                        state_reg <= H_CNV;
                    end else if (start_cal && armed_reg) begin
                        // Top up the clocks of this frame to the command count
                        cal_mode_reg <= 1'b1;
                        sclk_reg <= 1'b1;
                        phase_reg <= PHASE_W'(SCLK_HALF_CYCLES - 1);
                        state_reg <= H_CLK_HIGH;
                    end
                end
                H_CNV: begin
                    // Short select pulse, low well before the conversion ends
                    if (phase_zero) begin
                        cnv_reg <= 1'b0;
                        pulse_reg <= '0;
                        state_reg <= H_WAIT_BUSY;
                    end else begin
                        phase_reg <= phase_reg - 1'b1;
                    end
                end
                H_WAIT_BUSY: begin
                    // Falling data line is the completion interrupt
                    if (sdo_s2_reg == BUSY_LEVEL) begin
                        cal_mode_reg <= 1'b0;
                        sclk_reg <= 1'b1;
                        phase_reg <= PHASE_W'(SCLK_HALF_CYCLES - 1);
                        state_reg <= H_CLK_HIGH;
                    end
                end
                H_CLK_HIGH: begin
                    if (phase_zero) begin
                        sclk_reg <= 1'b0;
                        pulse_reg <= pulse_reg + 1'b1;
                        phase_reg <= PHASE_W'(SCLK_HALF_CYCLES - 1);
                        state_reg <= H_CLK_LOW;
                    end else begin
                        phase_reg <= phase_reg - 1'b1;
                    end
                end
                H_CLK_LOW: begin
                    if (phase_zero) begin
                        shift_reg <= shift_next;
                        if (frame_end && cal_mode_reg) begin
                            armed_reg <= 1'b0;
                            state_reg <= H_CAL_LOW;
                        end else if (frame_end) begin
                            result_code <= shift_next;
                            result_valid <= 1'b1;
                            armed_reg <= 1'b1;
                            state_reg <= H_IDLE;
                        end else begin
                            sclk_reg <= 1'b1;
                            phase_reg <= PHASE_W'(SCLK_HALF_CYCLES - 1);
                            state_reg <= H_CLK_HIGH;
                        end
                    end else begin
                        phase_reg <= phase_reg - 1'b1;
                    end
                end
                H_CAL_LOW: begin
                    // Wait for the device to pull the line low
                    if (sdo_s2_reg == BUSY_LEVEL) begin
                        state_reg <= H_CAL_HIGH;
                    end
                end
                H_CAL_HIGH: begin
                    // Pull-up level marks the end of calibration
                    if (sdo_s2_reg == SDO_PULL_LEVEL) begin
                        cal_done <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// *** abr_pkg.sv ***
// Summary of operation
// - Host holds mode select low for busy bit
// - Select rising edge starts conversion, releases output
// - Conversion completes regardless of select level
// - Conversion end: acquisition, drive low busy bit
// - Acquisition lasts until select rises again
// - Release output at 15th fall or select high
// - Shift result MSB first on falling edges
// - Host may sample on either clock edge
// - Host lowers select early, keeps low
// - Busy bit gives high-to-low interrupt edge
// - Host sends 1024 clocks in standby to recalibrate
// - Output low during recalibration, released after
// - Recalibration lasts about 500 ms
// - Clock idles low, data changes on falls
package abr_pkg;
    // Converter resolution and derived field sizes
    localparam int RES_BITS = 14;
    localparam int RES_IDX_W = $clog2(RES_BITS);
    typedef logic [RES_BITS-1:0] abr_code_t;

    // Core clock rate
    localparam int CORE_MHZ = 250;
    localparam int CORE_PERIOD_NS = 4;

    // Conversion timing; longest time rounds down, least time rounds up
    localparam int MIN_CONV_NS = 500;
    localparam int MAX_CONV_NS = 700;
    localparam int CONV_CYCLES = MAX_CONV_NS / CORE_PERIOD_NS;
    localparam int MIN_CONV_CYCLES = (MIN_CONV_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int CNV_HIGH_NS = 20;
    localparam int CNV_HIGH_CYCLES = (CNV_HIGH_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

    // Recalibration
    localparam int CAL_TIME_MS = 500;
    localparam int CAL_CYCLES = CAL_TIME_MS * 1000 * CORE_MHZ;
    localparam int CAL_CNT_W = 27;
    localparam int CAL_PULSES = 1024;

    // Link edge counting
    localparam int EDGE_CNT_W = 11;
    localparam int RELEASE_EDGE = RES_BITS + 1;

    // Host serial clock divider, core cycles per half period
    localparam int SCLK_HALF_CYCLES = 8;
    localparam int PHASE_W = 8;

    // Pin levels and reset values
    localparam logic MODE_BUSY_LEVEL = 1'b0;
    localparam logic SDO_PULL_LEVEL = 1'b1;
    localparam logic BUSY_LEVEL = 1'b0;
    localparam logic CNV_RST = 1'b0;
    localparam logic SCLK_RST = 1'b0;
endpackage

// *** abr_link_if.sv ***
interface abr_link_if;
    logic conversion_select;
    logic sclk;
    logic mode_select_input;
    logic sdo_out;
    logic sdo_oe_n;
    logic sdo;

    // Shared data line with external pull-up
    assign sdo = sdo_oe_n ? abr_pkg::SDO_PULL_LEVEL : sdo_out;

    modport dev (
        input conversion_select,
        input sclk,
        output sdo_out,
        output sdo_oe_n
    );

    modport host (
        output conversion_select,
        output sclk,
        output mode_select_input,
        input sdo
    );
endinterface

// *** abr_device.sv ***
module abr_device #(
    parameter int CAL_CYCLES_P = abr_pkg::CAL_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    abr_link_if.dev link,
    input wire abr_pkg::abr_code_t sample_code,
    output logic conv_active,
    output logic cal_active
);
    import abr_pkg::*;

    typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_CAL} abr_dev_state_t;

    // Core domain state
    abr_dev_state_t state_reg;
    abr_dev_state_t state_next;
    logic [CAL_CNT_W-1:0] timer_reg;
    logic [CAL_CNT_W-1:0] timer_next;
    abr_code_t result_reg;
    abr_code_t result_next;
    logic window_reg;
    logic window_next;

    // Synchronisers for the select pin and the recalibration request
    logic cnv_s1_reg;
    logic cnv_s2_reg;
    logic cnv_d_reg;
    logic cal_s1_reg;
    logic cal_s2_reg;
    logic cal_d_reg;

    // Link domain state, clocked by falling serial-clock edges
    logic [EDGE_CNT_W-1:0] edge_cnt_reg;
    logic bit_reg;
    logic done_reg;
    logic cal_hit_reg;

    // Decoded events in the core domain
    wire cnv_rise;
    wire cal_req;
    wire timer_zero;
    wire in_cal;
    wire in_conv;

    assign cnv_rise = cnv_s2_reg & ~cnv_d_reg;
    assign cal_req = cal_s2_reg & ~cal_d_reg;
    assign timer_zero = (timer_reg == '0);
    assign in_cal = (state_reg == ST_CAL);
    assign in_conv = (state_reg == ST_CONV);

    // Select pin and recalibration level cross into the core domain
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnv_s1_reg <= CNV_RST;
            cnv_s2_reg <= CNV_RST;
            cnv_d_reg <= CNV_RST;
            cal_s1_reg <= 1'b0;
            cal_s2_reg <= 1'b0;
            cal_d_reg <= 1'b0;
        end else if (clk_en) begin
            cnv_s1_reg <= link.conversion_select;
            cnv_s2_reg <= cnv_s1_reg;
            cnv_d_reg <= cnv_s2_reg;
            cal_s1_reg <= cal_hit_reg;
            cal_s2_reg <= cal_s1_reg;
            cal_d_reg <= cal_s2_reg;
        end
    end

    // Conversion and calibration sequencing
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        result_next = result_reg;
        window_next = window_reg;
        unique case (state_reg)
            ST_ACQ: begin
                if (cnv_rise) begin
                    // Rising select ends acquisition and starts a conversion
                    state_next = ST_CONV;
                    timer_next = CAL_CNT_W'(CONV_CYCLES - 1);
                    result_next = sample_code;
                    window_next = 1'b0;
                end else if (cal_req) begin
                    // Enough clocks seen in standby
                    state_next = ST_CAL;
                    timer_next = CAL_CNT_W'(CAL_CYCLES_P - 1);
                    window_next = 1'b0;
                end
            end
            ST_CONV: begin
                // Select level is ignored until the conversion ends
                if (timer_zero) begin
                    state_next = ST_ACQ;
                    window_next = 1'b1;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ST_CAL: begin
                // Hold the line low for the whole calibration
                if (timer_zero) begin
                    state_next = ST_ACQ;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
        endcase
    end

    // Core domain registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= ST_ACQ;
            timer_reg <= '0;
            result_reg <= '0;
            window_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            result_reg <= result_next;
            window_reg <= window_next;
        end
    end

    // Link-side decoding of the next edge count and the bit it selects
    wire [EDGE_CNT_W-1:0] edge_next;
    wire [EDGE_CNT_W-1:0] bit_pos;
    wire in_data;
    wire data_bit;
    wire cal_limit;

    assign cal_limit = (edge_cnt_reg == EDGE_CNT_W'(CAL_PULSES));
    assign edge_next = cal_limit ? edge_cnt_reg : edge_cnt_reg + 1'b1;
    assign bit_pos = EDGE_CNT_W'(RES_BITS) - edge_next;
    assign in_data = (edge_next != '0) && (edge_next <= EDGE_CNT_W'(RES_BITS));
    assign data_bit = in_data ? result_reg[bit_pos[RES_IDX_W-1:0]] : BUSY_LEVEL;

    // Falling-edge shifter; a high select ends the frame and clears it.
    // The result word only changes while select is high, so it is
    // stable whenever these flops are clocked.
    always_ff @(negedge link.sclk or posedge link.conversion_select) begin
        if (link.conversion_select) begin
            edge_cnt_reg <= '0;
            bit_reg <= BUSY_LEVEL;
            done_reg <= 1'b0;
            cal_hit_reg <= 1'b0;
        end else begin
            edge_cnt_reg <= edge_next;
            bit_reg <= data_bit;
            done_reg <= done_reg | (edge_next >= EDGE_CNT_W'(RELEASE_EDGE));
            cal_hit_reg <= (edge_next == EDGE_CNT_W'(CAL_PULSES));
        end
    end

    // Output driver: busy bit and data in the readout window, low in calibration.
    // A high select lets go of the line at once: the cleared done flag must not
    // reopen the old window while the core side still sees it open.
    wire drive_read;
    assign drive_read = window_reg & ~done_reg & ~link.conversion_select;
    assign link.sdo_oe_n = ~(drive_read | in_cal);
    assign link.sdo_out = bit_reg & window_reg & ~in_cal;

    // Status to the user side
    assign conv_active = in_conv;
    assign cal_active = in_cal;
endmodule

// *** abr_link_checker.sv ***
module abr_link_checker #(
    parameter int CAL_P = 200
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic conversion_select,
    input wire logic sclk,
    input wire logic mode_select_input,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic sdo
);
    logic [10:0] fall_cnt_reg;
    logic [31:0] low_cnt_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // Falling serial-clock edges since the select line last went high
    always_ff @(posedge core_clk) begin
        if (sys_rst || conversion_select) begin
            fall_cnt_reg <= '0;
        end else if ($fell(sclk) && fall_cnt_reg != 11'h7FF) begin
            fall_cnt_reg <= fall_cnt_reg + 11'h001;
        end
    end

    // Length of the current stretch in which the device drives the line
    always_ff @(posedge core_clk) begin
        if (sys_rst || sdo_oe_n) begin
            low_cnt_reg <= '0;
        end else begin
            low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
        end
    end

    // Protocol relations on the shared link
    chk_mode_held_low: assert property (mode_select_input == 1'b0)
        else $error("mode select left the busy-bit level");
    chk_start_releases: assert property ($rose(conversion_select) |-> sdo_oe_n)
        else $error("data line not released after conversion start");
    chk_busy_follows: assert property ($fell(conversion_select) |-> ##[100:300] (!sdo_oe_n && !sdo_out))
        else $error("no busy bit after the conversion");
    chk_busy_stays_low: assert property ($fell(sdo_oe_n) |-> ##1 (!sdo_out && !sdo_oe_n)[*3])
        else $error("driven line did not start low");
    chk_data_on_fall: assert property (($changed(sdo) && !sdo_oe_n && $past(sdo_oe_n) == 1'b0)
        |-> $fell(sclk))
        else $error("data changed away from a falling clock edge");
    chk_sclk_idle_low: assert property (conversion_select |-> !sclk)
        else $error("serial clock not idle low while select is high");
    chk_bits_driven: assert property ((fall_cnt_reg inside {[1:14]}) && !$fell(sclk) |-> !sdo_oe_n)
        else $error("line released before all data bits");
    chk_release_15th: assert property (($fell(sclk) && fall_cnt_reg == 11'd14) |-> sdo_oe_n)
        else $error("line not released at the fifteenth fall");
    chk_cal_engages: assert property ($rose(fall_cnt_reg == 11'd1024) |-> ##[0:8] !sdo_oe_n)
        else $error("calibration did not hold the line low");
    chk_cal_length: assert property (($rose(sdo_oe_n) && fall_cnt_reg == 11'd1024)
        |-> low_cnt_reg inside {[CAL_P:CAL_P + 8]})
        else $error("calibration length out of range");
endmodule

// *** testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import abr_pkg::*;
    localparam int CAL_P = 200;
    typedef struct {abr_code_t code; abr_code_t exp;} abr_row_t;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic start_conv = 1'b0;
    logic start_cal = 1'b0;
    abr_code_t sample_code = '0;
    abr_code_t sample_b = '0;
    abr_code_t result_code;
    logic ready, result_valid, cal_done, conv_active, cal_active, conv_b, cal_b;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int k, hi, lo;
    abr_row_t rows [5] = '{'{14'h0000, 14'h0000}, '{14'h3FFF, 14'h3FFF},
        '{14'h2AAA, 14'h2AAA}, '{14'h1555, 14'h1555}, '{14'h2001, 14'h2001}};

    abr_link_if link_a ();
    abr_link_if link_b ();
    abr_device #(.CAL_CYCLES_P(CAL_P)) abr_device_inst (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .link(link_a), .sample_code(sample_code),
        .conv_active(conv_active), .cal_active(cal_active));
    abr_host abr_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .link(link_a), .start_conv(start_conv), .start_cal(start_cal), .ready(ready),
        .result_code(result_code), .result_valid(result_valid), .cal_done(cal_done));
    abr_device #(.CAL_CYCLES_P(CAL_P)) abr_device_inst2 (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(clk_en), .link(link_b), .sample_code(sample_b),
        .conv_active(conv_b), .cal_active(cal_b));
    abr_link_checker #(.CAL_P(CAL_P)) abr_link_checker_inst (.core_clk(core_clk),
        .sys_rst(sys_rst), .conversion_select(link_a.conversion_select), .sclk(link_a.sclk),
        .mode_select_input(link_a.mode_select_input), .sdo_out(link_a.sdo_out),
        .sdo_oe_n(link_a.sdo_oe_n), .sdo(link_a.sdo));

    // Core clock and hang guard
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask

    // One readout through the host end
    task automatic convert(abr_code_t code, abr_code_t exp);
        for (k = 0; k < 50 && ready !== 1'b1; k++) @(negedge core_clk);
        sample_code = code;
        start_conv = 1'b1;
        @(negedge core_clk);
        start_conv = 1'b0;
        for (k = 0; k < 900 && result_valid !== 1'b1; k++) @(negedge core_clk);
        check("result_code", exp, result_code);
    endtask

    // Serial clock pulses on the second link, data looked at in the low half
    task automatic clock_b(int n, abr_code_t code);
        for (int j = 1; j <= n; j++) begin
            link_b.sclk = 1'b1;
            #80;
            link_b.sclk = 1'b0;
            #40;
            check("data bit", (j == 15) ? 1'b1 : code[14 - j], link_b.sdo);
            #40;
        end
    endtask

    task automatic wait_busy_b();
        for (k = 0; k < 400 && link_b.sdo !== 1'b0; k++) @(negedge core_clk);
        check("busy b", 0, link_b.sdo);
    endtask

    // Main sequence
    initial begin
        link_b.mode_select_input = 1'b0;
        link_b.conversion_select = 1'b0;
        link_b.sclk = 1'b0;
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        foreach (rows[i]) convert(rows[i].code, rows[i].exp);
        sys_rst = 1'b1;
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        check("ready", 1, ready);
        check("sclk idle", 0, link_a.sclk);
        check("sdo idle", 1, link_a.sdo);
        start_cal = 1'b1;
        @(negedge core_clk);
        start_cal = 1'b0;
        repeat (20) @(negedge core_clk);
        check("cal refused", 1, ready);
        convert(14'h0F0F, 14'h0F0F);
        start_cal = 1'b1;
        @(negedge core_clk);
        start_cal = 1'b0;
        for (k = 0; k < 20000 && cal_active !== 1'b1; k++) @(negedge core_clk);
        hi = 0;
        lo = 0;
        while (cal_active === 1'b1 && hi < 1000) begin
            hi++;
            if (link_a.sdo === 1'b0) lo++;
            @(negedge core_clk);
        end
        check("cal low", hi, lo);
        check("cal length", 1, hi >= CAL_P && hi <= CAL_P + 8);
        for (k = 0; k < 50 && cal_done !== 1'b1; k++) @(negedge core_clk);
        check("cal_done", 1, cal_done);
        check("sdo after cal", 1, link_a.sdo);
        convert(14'h3A5C, 14'h3A5C);
        // Second link: select line reused mid-conversion, then an early release
        #1.3;
        sample_b = 14'h2C71;
        link_b.conversion_select = 1'b1;
        #40;
        link_b.conversion_select = 1'b0;
        check("start release", 1, link_b.sdo);
        sample_b = 14'h0333;
        #40;
        link_b.conversion_select = 1'b1;
        #40;
        link_b.conversion_select = 1'b0;
        wait_busy_b();
        clock_b(3, 14'h2C71);
        link_b.conversion_select = 1'b1;
        #20;
        check("early release", 1, link_b.sdo);
        #20;
        link_b.conversion_select = 1'b0;
        wait_busy_b();
        clock_b(15, 14'h0333);
        #400;
        check("acquisition", 0, conv_b);
        wrap_up();
    end
endmodule
